// ===== verilog/audio_port_pkg.sv
// constants shared by the audio port status and format block
// assumes a 250 MHz reference clock and a two-wire control bus slave
package audio_port_pkg;

	// register offsets on the control bus
	localparam logic [7:0] OFS_CLK_STATUS = 8'h00;
	localparam logic [7:0] OFS_REV_ID     = 8'h01;
	localparam logic [7:0] OFS_ERR_FLAGS  = 8'h02;
	localparam logic [7:0] OFS_SYS_CTRL1  = 8'h03;
	localparam logic [7:0] OFS_SER_FMT    = 8'h04;

	// values after reset
	localparam logic [7:0] RST_CLK_STATUS = 8'h6c;
	localparam logic [7:0] RST_ERR_FLAGS  = 8'h00;
	localparam logic [7:0] RST_SYS_CTRL1  = 8'h80;
	localparam logic [7:0] RST_SER_FMT    = 8'h05;

	// error flag positions
	localparam int ERR_MCLK  = 7;
	localparam int ERR_PLL   = 6;
	localparam int ERR_BCLK  = 5;
	localparam int ERR_FRAME = 4;
	localparam int ERR_SLIP  = 3;
	localparam int ERR_CLIP  = 2;
	localparam int ERR_FAULT = 1;
	localparam logic [7:0] ERR_USED_MASK = 8'hfe;

	// system control 1 field positions
	localparam int CTL_DC_BLOCK    = 7;
	localparam int CTL_HARD_UNMUTE = 5;

	// sample rate codes, bits 7..5 of clock status
	localparam logic [2:0] RATE_32K = 3'h0;
	localparam logic [2:0] RATE_48K = 3'h3;
	localparam logic [2:0] RATE_16K = 3'h4;
	localparam logic [2:0] RATE_24K = 3'h5;
	localparam logic [2:0] RATE_8K  = 3'h6;
	localparam logic [2:0] RATE_12K = 3'h7;

	// master clock ratio codes, bits 4..2 of clock status
	localparam logic [2:0] RATIO_64  = 3'h0;
	localparam logic [2:0] RATIO_128 = 3'h1;
	localparam logic [2:0] RATIO_192 = 3'h2;
	localparam logic [2:0] RATIO_256 = 3'h3;
	localparam logic [2:0] RATIO_384 = 3'h4;
	localparam logic [2:0] RATIO_512 = 3'h5;

	// frame period limits in reference cycles at 250 MHz
	localparam logic [15:0] PER_MAX_48K = 16'd6500;
	localparam logic [15:0] PER_MAX_32K = 16'd9000;
	localparam logic [15:0] PER_MAX_24K = 16'd13000;
	localparam logic [15:0] PER_MAX_16K = 16'd18000;
	localparam logic [15:0] PER_MAX_12K = 16'd27000;
	localparam logic [15:0] PER_TOL     = 16'd8;

	// frame watchdog: time and cycle count
	localparam int REF_CLK_MHZ       = 250;
	localparam int FRAME_TIMEOUT_US  = 200;
	localparam int FRAME_TIMEOUT_CYC = FRAME_TIMEOUT_US * REF_CLK_MHZ;

	// unmute ramp
	localparam logic [9:0] RAMP_STEPS      = 10'd512;
	localparam logic [1:0] FRAMES_PER_STEP = 2'd3;

	// last valid serial format code
	localparam logic [3:0] FMT_LAST_VALID = 4'h8;

	// control bus slave states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_ADDR = 5'b00010,
		ST_SUB  = 5'b00100,
		ST_WR   = 5'b01000,
		ST_RD   = 5'b10000
	} bus_state_t;

endpackage

// ===== verilog/link_rate_monitor.sv
// measures master and bit clocks per frame on the master clock domain
// assumes bit clock at most half the master clock; frame and bit clocks are pins
`timescale 1ns/10ps
`default_nettype none
module link_rate_monitor
	import audio_port_pkg::*;
(
	// link clock and reference-domain reset
	input  wire logic       master_clk,
	input  wire logic       rst,
	// link pins
	input  wire logic       bit_clk,
	input  wire logic       frame_clk,
	// per-frame results, stable between toggles
	output logic            upd_toggle_r,
	output logic [9:0]      mclk_count_r,
	output logic [8:0]      bclk_count_r,
	output logic            mclk_changed_r,
	output logic            bclk_changed_r,
	output logic            frame_slipped_r
);

	logic [1:0] rst_sync_r;
	logic       bclk_meta_r, bclk_sync_r, bclk_prev_r;
	logic       frame_meta_r, frame_sync_r, frame_prev_r;
	logic [9:0] mcnt_r;
	logic [8:0] bcnt_r;
	logic [9:0] phase_r;
	logic       locked_r;
	logic       link_rst;
	logic       frame_rise;
	logic       bclk_rise;
	logic [9:0] period;

	assign link_rst   = rst_sync_r[1];
	assign frame_rise = frame_sync_r & ~frame_prev_r;
	assign bclk_rise  = bclk_sync_r & ~bclk_prev_r;
	assign period     = (mcnt_r == 10'h3ff) ? mcnt_r : mcnt_r + 10'd1;

	// reset brought into this domain through two stages
	always_ff @(posedge master_clk) begin
		rst_sync_r <= {rst_sync_r[0], rst};
	end

	// pin synchronisers; the second and third stages are read, the first only feeds the second
	always_ff @(posedge master_clk) begin
		bclk_meta_r  <= bit_clk;
		bclk_sync_r  <= bclk_meta_r;
		bclk_prev_r  <= bclk_sync_r;
		frame_meta_r <= frame_clk;
		frame_sync_r <= frame_meta_r;
		frame_prev_r <= frame_sync_r;
	end

	// clock counting within one frame, saturating
	always_ff @(posedge master_clk) begin
		if (link_rst) begin
			mcnt_r <= 10'h000;
			bcnt_r <= 9'h000;
		end else if (frame_rise) begin
			mcnt_r <= 10'h000;
			bcnt_r <= {8'h00, bclk_rise};
		end else begin
			mcnt_r <= period;
			if (bclk_rise && bcnt_r != 9'h1ff)
				bcnt_r <= bcnt_r + 9'd1;
		end
	end

	// internal frame sync free-runs on the last period
	always_ff @(posedge master_clk) begin
		if (link_rst) begin
			phase_r <= 10'h000;
		end else if (frame_rise || phase_r + 10'd1 >= mclk_count_r) begin
			phase_r <= 10'h000;
		end else begin
			phase_r <= phase_r + 10'd1;
		end
	end

	// per-frame results and change flags, published by a toggle
	always_ff @(posedge master_clk) begin
		if (link_rst) begin
			upd_toggle_r    <= 1'b0;
			mclk_count_r    <= 10'h000;
			bclk_count_r    <= 9'h000;
			mclk_changed_r  <= 1'b0;
			bclk_changed_r  <= 1'b0;
			frame_slipped_r <= 1'b0;
			locked_r        <= 1'b0;
		end else if (frame_rise) begin
			upd_toggle_r    <= ~upd_toggle_r;
			mclk_count_r    <= period;
			bclk_count_r    <= bcnt_r;
			mclk_changed_r  <= locked_r && period != mclk_count_r;
			bclk_changed_r  <= locked_r && bcnt_r != bclk_count_r;
			frame_slipped_r <= locked_r && phase_r + 10'd1 != mclk_count_r;
			locked_r        <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// ===== verilog/audio_port_status.sv
// audio port clock status, sticky errors and format control
// assumes an external serial audio source and a two-wire control bus master
`timescale 1ns/10ps
`default_nettype none
module audio_port_status
	import audio_port_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR      = 7'h2a,  // arbitrary bus address
	parameter logic [7:0]  REV_ID        = 8'h5a,  // arbitrary revision code
	parameter logic [15:0] FRAME_TIMEOUT = 16'(FRAME_TIMEOUT_CYC)
)(
	// reference clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// control bus pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// serial audio clocks
	input  wire logic       master_clk,
	input  wire logic       bit_clk,
	input  wire logic       frame_clk,
	// fault reports from neighbouring logic on ref_clk
	input  wire logic       pll_lock_fail,
	input  wire logic       clip_detect,
	input  wire logic       protect_fault,
	// control outputs to the audio path
	output logic            dc_block_en,
	output logic            hard_unmute_en,
	output logic [1:0]      deemph_sel,
	output logic [1:0]      rx_justify,
	output logic [1:0]      rx_word_len,
	output logic [9:0]      unmute_level,
	output logic            clock_fault
);

	// link monitor results
	logic       upd_toggle;
	logic [9:0] mclk_count;
	logic [8:0] bclk_count;
	logic       mclk_changed;
	logic       bclk_changed;
	logic       frame_slipped;

	// crossing and frame timing
	logic        tog_meta_r, tog_sync_r, tog_prev_r;
	logic        upd;
	logic [15:0] per_cnt_r;
	logic [15:0] per_last_r;
	logic        per_valid_r;
	logic        frame_chg;
	logic        timeout_hit;
	logic [1:0]  step_cnt_r;

	// register file
	logic [7:0] clk_status_r;
	logic [7:0] err_r;
	logic [7:0] sys_ctrl1_r;
	logic [7:0] ser_fmt_r;
	logic [7:0] err_set;
	logic       clk_err_event;
	logic [3:0] ratio_now;
	logic [7:0] rd_cur;
	logic [7:0] rd_next;

	// control bus slave
	bus_state_t state_r;
	logic       scl_meta_r, scl_s_r, scl_p_r;
	logic       sda_meta_r, sda_s_r, sda_p_r;
	logic [3:0] cnt_r;
	logic [7:0] sh_r;
	logic [7:0] ptr_r;
	logic       sda_oe_r;
	logic       sda_out_r;
	logic       wr_stb_r;
	logic [7:0] wr_addr_r;
	logic [7:0] wr_data_r;
	logic       scl_rise, scl_fall, bus_start, bus_stop;

	// output flops
	logic       dc_block_en_r;
	logic       hard_unmute_en_r;
	logic [1:0] deemph_sel_r;
	logic [1:0] rx_justify_r;
	logic [1:0] rx_word_len_r;
	logic [9:0] unmute_level_r;
	logic       clock_fault_r;

	// sample rate class from frame period in reference cycles
	function automatic logic [2:0] rate_code(input logic [15:0] per);
		if (per <= PER_MAX_48K)
			rate_code = RATE_48K;
		else if (per <= PER_MAX_32K)
			rate_code = RATE_32K;
		else if (per <= PER_MAX_24K)
			rate_code = RATE_24K;
		else if (per <= PER_MAX_16K)
			rate_code = RATE_16K;
		else if (per <= PER_MAX_12K)
			rate_code = RATE_12K;
		else
			rate_code = RATE_8K;
	endfunction

	// ratio code plus valid bit from master clocks per frame
	function automatic logic [3:0] ratio_code(input logic [9:0] n);
		case (n)
			10'd64:  ratio_code = {1'b1, RATIO_64};
			10'd128: ratio_code = {1'b1, RATIO_128};
			10'd192: ratio_code = {1'b1, RATIO_192};
			10'd256: ratio_code = {1'b1, RATIO_256};
			10'd384: ratio_code = {1'b1, RATIO_384};
			10'd512: ratio_code = {1'b1, RATIO_512};
			default: ratio_code = 4'h0;
		endcase
	endfunction

	// read data for a register offset; unmapped reads zero
	function automatic logic [7:0] rd_byte(input logic [7:0] ofs, input logic [7:0] cs,
		input logic [7:0] er, input logic [7:0] c1, input logic [7:0] sf);
		case (ofs)
			OFS_CLK_STATUS: rd_byte = cs;
			OFS_REV_ID:     rd_byte = REV_ID;
			OFS_ERR_FLAGS:  rd_byte = er;
			OFS_SYS_CTRL1:  rd_byte = c1;
			OFS_SER_FMT:    rd_byte = sf;
			default:        rd_byte = 8'h00;
		endcase
	endfunction

	link_rate_monitor u_link (
		.master_clk      (master_clk),
		.rst             (rst),
		.bit_clk         (bit_clk),
		.frame_clk       (frame_clk),
		.upd_toggle_r    (upd_toggle),
		.mclk_count_r    (mclk_count),
		.bclk_count_r    (bclk_count),
		.mclk_changed_r  (mclk_changed),
		.bclk_changed_r  (bclk_changed),
		.frame_slipped_r (frame_slipped)
	);

	// toggle crossing; words are held a whole frame, so they are stable when sampled
	always_ff @(posedge ref_clk) begin
		tog_meta_r <= upd_toggle;
		tog_sync_r <= tog_meta_r;
		tog_prev_r <= tog_sync_r;
	end
	assign upd = tog_sync_r ^ tog_prev_r;

	// frame period in reference cycles, with a watchdog for stopped clocks
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			per_cnt_r   <= 16'h0000;
			per_last_r  <= 16'h0000;
			per_valid_r <= 1'b0;
		end else if (upd) begin
			per_cnt_r   <= 16'h0000;
			per_last_r  <= per_cnt_r;
			per_valid_r <= 1'b1;
		end else if (per_cnt_r != 16'hffff) begin
			per_cnt_r <= per_cnt_r + 16'd1;
		end
	end
	assign frame_chg = upd && per_valid_r && (per_cnt_r > per_last_r + PER_TOL ||
		per_cnt_r + PER_TOL < per_last_r);
	assign timeout_hit = per_valid_r && per_cnt_r == FRAME_TIMEOUT;

	// detected clock status, ignoring software writes
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clk_status_r <= RST_CLK_STATUS;
		end else if (upd && per_valid_r) begin
			clk_status_r[7:5] <= rate_code(per_cnt_r);
			if (ratio_now[3])
				clk_status_r[4:2] <= ratio_now[2:0];
			clk_status_r[1:0] <= 2'b00;
		end
	end

	// sticky error events
	always_comb begin
		err_set            = 8'h00;
		err_set[ERR_MCLK]  = (upd && mclk_changed) || timeout_hit;
		err_set[ERR_PLL]   = pll_lock_fail;
		err_set[ERR_BCLK]  = upd && bclk_changed;
		err_set[ERR_FRAME] = frame_chg;
		err_set[ERR_SLIP]  = upd && frame_slipped;
		err_set[ERR_CLIP]  = clip_detect;
		err_set[ERR_FAULT] = protect_fault;
	end
	assign clk_err_event = err_set[ERR_MCLK] | err_set[ERR_BCLK] | err_set[ERR_FRAME] |
		err_set[ERR_SLIP];

	// error flags: only a written zero clears, a new event wins over the clear
	always_ff @(posedge ref_clk) begin
		if (rst)
			err_r <= RST_ERR_FLAGS;
		else if (wr_stb_r && wr_addr_r == OFS_ERR_FLAGS)
			err_r <= ((err_r & wr_data_r) | err_set) & ERR_USED_MASK;
		else
			err_r <= (err_r | err_set) & ERR_USED_MASK;
	end

	// writable control registers; status and id offsets take no write
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sys_ctrl1_r <= RST_SYS_CTRL1;
			ser_fmt_r   <= RST_SER_FMT;
		end else if (wr_stb_r) begin
			if (wr_addr_r == OFS_SYS_CTRL1)
				sys_ctrl1_r <= wr_data_r & 8'ha3;
			if (wr_addr_r == OFS_SER_FMT && wr_data_r[7:4] == 4'h0 &&
				wr_data_r[3:0] <= FMT_LAST_VALID)
				ser_fmt_r <= wr_data_r;
		end
	end

	// control decodes to the audio path
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dc_block_en_r    <= 1'b1;
			hard_unmute_en_r <= 1'b0;
			deemph_sel_r     <= 2'b00;
			rx_justify_r     <= 2'd1;
			rx_word_len_r    <= 2'd2;
		end else begin
			dc_block_en_r    <= sys_ctrl1_r[CTL_DC_BLOCK];
			hard_unmute_en_r <= sys_ctrl1_r[CTL_HARD_UNMUTE];
			deemph_sel_r     <= sys_ctrl1_r[1:0];
			if (ser_fmt_r[3:0] < 4'd3) begin
				rx_justify_r  <= 2'd0;
				rx_word_len_r <= ser_fmt_r[1:0];
			end else if (ser_fmt_r[3:0] < 4'd6) begin
				rx_justify_r  <= 2'd1;
				rx_word_len_r <= 2'(ser_fmt_r[3:0] - 4'd3);
			end else begin
				rx_justify_r  <= 2'd2;
				rx_word_len_r <= 2'(ser_fmt_r[3:0] - 4'd6);
			end
		end
	end

	// clock fault lasts until a frame arrives clean
	always_ff @(posedge ref_clk) begin
		if (rst)
			clock_fault_r <= 1'b1;
		else if (clk_err_event)
			clock_fault_r <= 1'b1;
		else if (upd && per_valid_r)
			clock_fault_r <= 1'b0;
	end

	// unmute ramp: one step per four frames, or a single jump when hard
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			unmute_level_r <= 10'd0;
			step_cnt_r     <= 2'd0;
		end else if (clock_fault_r) begin
			unmute_level_r <= 10'd0;
			step_cnt_r     <= 2'd0;
		end else if (sys_ctrl1_r[CTL_HARD_UNMUTE]) begin
			unmute_level_r <= RAMP_STEPS;
		end else if (upd && unmute_level_r < RAMP_STEPS) begin
			step_cnt_r <= step_cnt_r + 2'd1;
			if (step_cnt_r == FRAMES_PER_STEP)
				unmute_level_r <= unmute_level_r + 10'd1;
		end
	end

	// bus pin synchronisers
	always_ff @(posedge ref_clk) begin
		scl_meta_r <= scl_in;
		scl_s_r    <= scl_meta_r;
		scl_p_r    <= scl_s_r;
		sda_meta_r <= sda_in;
		sda_s_r    <= sda_meta_r;
		sda_p_r    <= sda_s_r;
	end
	assign scl_rise  = scl_s_r & ~scl_p_r;
	assign scl_fall  = ~scl_s_r & scl_p_r;
	assign bus_start = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
	assign bus_stop  = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;

	// decoded ratio and read bytes, named so their bits can be picked
	assign ratio_now = ratio_code(mclk_count);
	assign rd_cur    = rd_byte(ptr_r, clk_status_r, err_r, sys_ctrl1_r, ser_fmt_r);
	assign rd_next   = rd_byte(ptr_r + 8'd1, clk_status_r, err_r, sys_ctrl1_r, ser_fmt_r);

	// open-drain data line only ever pulls low
	always_ff @(posedge ref_clk) begin
		sda_out_r <= 1'b0;
	end

	// control bus slave: address, subaddress, auto-incrementing data
	always_ff @(posedge ref_clk) begin
		wr_stb_r <= 1'b0;
		if (rst) begin
			state_r   <= ST_IDLE;
			cnt_r     <= 4'd0;
			sh_r      <= 8'h00;
			ptr_r     <= 8'h00;
			sda_oe_r  <= 1'b0;
			wr_addr_r <= 8'h00;
			wr_data_r <= 8'h00;
		end else if (bus_start) begin
			state_r  <= ST_ADDR;
			cnt_r    <= 4'd0;
			sda_oe_r <= 1'b0;
		end else if (bus_stop) begin
			state_r  <= ST_IDLE;
			sda_oe_r <= 1'b0;
		end else if (scl_rise) begin
			case (state_r)
				ST_ADDR, ST_SUB, ST_WR: begin
					if (cnt_r < 4'd8) begin
						sh_r  <= {sh_r[6:0], sda_s_r};
						cnt_r <= cnt_r + 4'd1;
					end
				end
				ST_RD: begin
					if (cnt_r == 4'd9 && sda_s_r)
						state_r <= ST_IDLE; // master declined more data
				end
				default: ;
			endcase
		end else if (scl_fall) begin
			case (state_r)
				ST_ADDR: begin
					if (cnt_r == 4'd8 && sh_r[7:1] == DEV_ADDR) begin
						sda_oe_r <= 1'b1;
						cnt_r    <= 4'd9;
					end else if (cnt_r == 4'd8) begin
						state_r <= ST_IDLE;
					end else if (cnt_r == 4'd9 && sh_r[0]) begin
						state_r  <= ST_RD;
						sh_r     <= rd_cur;
						sda_oe_r <= ~rd_cur[7];
						cnt_r    <= 4'd1;
					end else if (cnt_r == 4'd9) begin
						state_r  <= ST_SUB;
						sda_oe_r <= 1'b0;
						cnt_r    <= 4'd0;
					end
				end
				ST_SUB, ST_WR: begin
					if (cnt_r == 4'd8) begin
						sda_oe_r <= 1'b1;
						cnt_r    <= 4'd9;
						if (state_r == ST_WR) begin
							wr_stb_r  <= 1'b1;
							wr_addr_r <= ptr_r;
							wr_data_r <= sh_r;
						end
					end else if (cnt_r == 4'd9) begin
						sda_oe_r <= 1'b0;
						cnt_r    <= 4'd0;
						state_r  <= ST_WR;
						ptr_r    <= (state_r == ST_SUB) ? sh_r : ptr_r + 8'd1;
					end
				end
				ST_RD: begin
					if (cnt_r < 4'd8) begin
						sda_oe_r <= ~sh_r[6];
						sh_r     <= {sh_r[6:0], 1'b0};
						cnt_r    <= cnt_r + 4'd1;
					end else if (cnt_r == 4'd8) begin
						sda_oe_r <= 1'b0;
						cnt_r    <= 4'd9;
					end else begin
						ptr_r    <= ptr_r + 8'd1;
						sh_r     <= rd_next;
						sda_oe_r <= ~rd_next[7];
						cnt_r    <= 4'd1;
					end
				end
				default: ;
			endcase
		end
	end

	// outputs straight from flops
	assign sda_out        = sda_out_r;
	assign sda_oe         = sda_oe_r;
	assign dc_block_en    = dc_block_en_r;
	assign hard_unmute_en = hard_unmute_en_r;
	assign deemph_sel     = deemph_sel_r;
	assign rx_justify     = rx_justify_r;
	assign rx_word_len    = rx_word_len_r;
	assign unmute_level   = unmute_level_r;
	assign clock_fault    = clock_fault_r;

endmodule
`default_nettype wire

// ===== verification/audio_source_model.sv
// serial audio clock source model standing in for the audio processor
// assumes the bench sets run and the master clocks per frame
`timescale 1ns/10ps
`default_nettype none
module audio_source_model (
	// control from the bench
	input  wire logic       run,
	input  wire logic [9:0] ratio,
	// link clocks
	output logic            master_clk,
	output logic            bit_clk,
	output logic            frame_clk
);
	logic [9:0] cnt_r = 10'h000;

	// 48 ns master clock, stands still while halted
	initial begin
		master_clk = 1'b0;
		#7;
		forever begin
			#24;
			if (run)
				master_clk = ~master_clk;
		end
	end

	// a ratio change mid-frame gives one odd frame, as real sources do
	always @(posedge master_clk)
		cnt_r <= (cnt_r >= ratio - 10'd1) ? 10'h000 : cnt_r + 10'd1;

	// bit clock a quarter of master, frame high for the first half
	assign bit_clk   = cnt_r[1];
	assign frame_clk = cnt_r < (ratio >> 1);
endmodule
`default_nettype wire

// ===== verification/audio_port_properties.sv
// concurrent checks on the audio port status block
// sees only the top ports; bound in at the foot
`timescale 1ns/10ps
`default_nettype none
module audio_port_properties
	import audio_port_pkg::*;
#(
	parameter logic [15:0] FRAME_TIMEOUT = 16'd50000
)(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// pins
	input  wire logic       scl_in,
	input  wire logic       frame_clk,
	// audio path controls
	input  wire logic       dc_block_en,
	input  wire logic       hard_unmute_en,
	input  wire logic [1:0] deemph_sel,
	input  wire logic [1:0] rx_justify,
	input  wire logic [1:0] rx_word_len,
	input  wire logic [9:0] unmute_level,
	input  wire logic       clock_fault
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [1:0]  fr_r;
	logic [15:0] gap_r;

	// ref cycles since the last frame start, saturating
	always_ff @(posedge ref_clk) begin
		fr_r <= {fr_r[0], frame_clk};
		if (rst || fr_r == 2'b01)
			gap_r <= 16'h0000;
		else if (gap_r != 16'hffff)
			gap_r <= gap_r + 16'h0001;
	end

	a_reset_defaults: assert property ($fell(rst) |-> dc_block_en && !hard_unmute_en
		&& deemph_sel == 2'h0 && rx_justify == 2'h1 && rx_word_len == 2'h2)
		else $error("control pins wrong after reset");
	a_format_legal: assert property (rx_justify != 2'h3 && rx_word_len != 2'h3)
		else $error("reserved receive format on pins");
	a_ramp_bound: assert property (unmute_level <= 10'd512)
		else $error("unmute level above full scale");
	a_soft_step: assert property (!hard_unmute_en && !$past(hard_unmute_en)
		&& !clock_fault && !$past(clock_fault) && unmute_level != $past(unmute_level)
		|-> unmute_level == $past(unmute_level) + 10'd1)
		else $error("soft unmute jumped");
	a_hard_step: assert property (hard_unmute_en && $fell(clock_fault)
		|-> ##[0:2] unmute_level == 10'd512)
		else $error("hard unmute not in one step");
	a_stall_fault: assert property (gap_r > FRAME_TIMEOUT + 16'd300 |-> clock_fault)
		else $error("missing frames not flagged");
	a_fault_clear: assert property ($fell(clock_fault) |-> gap_r < 16'd150)
		else $error("clock fault cleared without a frame");
	a_ctrl_on_write: assert property ($changed({dc_block_en, hard_unmute_en,
		deemph_sel, rx_justify, rx_word_len}) |-> !scl_in)
		else $error("controls changed outside a bus write");

	c_hard: cover property (hard_unmute_en && $fell(clock_fault));
	c_full: cover property ($rose(unmute_level == 10'd512));
	c_stall: cover property ($rose(clock_fault));
endmodule

bind audio_port_status audio_port_properties #(.FRAME_TIMEOUT(FRAME_TIMEOUT))
	audio_port_properties_i (.ref_clk(ref_clk), .rst(rst), .scl_in(scl_in),
	.frame_clk(frame_clk), .dc_block_en(dc_block_en), .hard_unmute_en(hard_unmute_en),
	.deemph_sel(deemph_sel), .rx_justify(rx_justify), .rx_word_len(rx_word_len),
	.unmute_level(unmute_level), .clock_fault(clock_fault));
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the audio port status block
// drives the two-wire bus pins and a clock source model
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
module tb
	import audio_port_pkg::*;
;
	localparam logic [6:0] DEV = 7'h2a;
	localparam logic [7:0] REV = 8'h3c; // arbitrary revision code
	localparam int         Q   = 3;     // ref cycles per quarter bus bit; keeps the run short
	logic ref_clk = 1'b0, rst = 1'b1, scl = 1'b1, sda_m = 1'b1, run = 1'b1;
	logic [9:0] ratio = 10'd256;
	logic [2:0] flt = 3'h0;
	logic sda_out, sda_oe, mclk, bclk, fclk, dc, hu, cf;
	logic [1:0] de, rj, wl;
	logic [9:0] lvl;
	logic [31:0] seed = 32'hf34d149e;
	logic [7:0] rd;
	logic [9:0] rt [3] = '{10'd192, 10'd384, 10'd512};
	logic [2:0] rc [3] = '{3'h2, 3'h4, 3'h5};
	logic [7:0] fm [3] = '{8'h02, 8'h04, 8'h40};
	int bad_count = 0, total_checks = 0, cyc = 0;
	wire logic sda = sda_m & ~sda_oe; // open drain line

	audio_port_status #(.DEV_ADDR(DEV), .REV_ID(REV), .FRAME_TIMEOUT(16'd8000))
	audio_port_status_i (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .master_clk(mclk), .bit_clk(bclk),
		.frame_clk(fclk), .pll_lock_fail(flt[2]), .clip_detect(flt[1]),
		.protect_fault(flt[0]), .dc_block_en(dc), .hard_unmute_en(hu), .deemph_sel(de),
		.rx_justify(rj), .rx_word_len(wl), .unmute_level(lvl), .clock_fault(cf));
	audio_source_model audio_source_model_i (.run(run), .ratio(ratio),
		.master_clk(mclk), .bit_clk(bclk), .frame_clk(fclk));

	always #2 ref_clk = ~ref_clk;

	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 100000) begin
			bad_count++;
			summarize();
		end
	end

	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	// justify and word length pins for a format code
	function automatic logic [3:0] fmt_pins(logic [3:0] c);
		return {2'(c / 4'd3), 2'(c % 4'd3)};
	endfunction

	task automatic wt(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic bit_io(logic b, output logic r);
		sda_m = b;
		wt(Q);
		scl = 1'b1;
		wt(Q);
		r = sda;
		wt(Q);
		scl = 1'b0;
		wt(Q);
	endtask
	task automatic start();
		sda_m = 1'b1;
		wt(Q);
		scl = 1'b1;
		wt(Q);
		sda_m = 1'b0;
		wt(Q);
		scl = 1'b0;
		wt(Q);
	endtask
	task automatic stop();
		sda_m = 1'b0;
		wt(Q);
		scl = 1'b1;
		wt(Q);
		sda_m = 1'b1;
		wt(Q);
	endtask
	// byte out, then the ack level expected
	task automatic put(logic [7:0] d, logic a);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		`CHK("ack", a, r)
	endtask
	task automatic wr(logic [7:0] o, logic [7:0] d);
		start();
		put({DEV, 1'b0}, 1'b0);
		put(o, 1'b0);
		put(d, 1'b0);
		stop();
	endtask
	task automatic rdr(logic [7:0] o);
		logic r;
		start();
		put({DEV, 1'b0}, 1'b0);
		put(o, 1'b0);
		start();
		put({DEV, 1'b1}, 1'b0);
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			rd[i] = r;
		end
		bit_io(1'b1, r);
		stop();
	endtask
	task automatic chk_reg(string n, logic [7:0] o, logic [7:0] e);
		rdr(o);
		`CHK(n, e, rd)
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		logic [7:0] v, c1, cur;
		wt(50); // long enough for several link clock edges
		rst = 1'b0;
		wt(5);
		chk_reg("clk status", OFS_CLK_STATUS, 8'h6c);
		chk_reg("rev id", OFS_REV_ID, REV);
		chk_reg("errors", OFS_ERR_FLAGS, 8'h00);
		chk_reg("ctrl1", OFS_SYS_CTRL1, 8'h80);
		chk_reg("format", OFS_SER_FMT, 8'h05);
		$display("reset test done");
		wr(OFS_CLK_STATUS, 8'h00);
		wr(OFS_REV_ID, ~REV);
		wr(8'h07, 8'hff);
		chk_reg("clk status", OFS_CLK_STATUS, 8'h6c);
		chk_reg("rev id", OFS_REV_ID, REV);
		start();
		put({~DEV, 1'b0}, 1'b1);
		stop();
		$display("read-only test done");
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			c1 = {v[7:2], i[1:0]};
			wr(OFS_SYS_CTRL1, c1);
			chk_reg("ctrl1", OFS_SYS_CTRL1, c1 & 8'ha3);
			`CHK("ctrl pins", {c1[7], c1[5], c1[1:0]}, {dc, hu, de})
		end
		wr(OFS_SYS_CTRL1, 8'h80);
		$display("control test done");
		cur = 8'h05;
		for (int i = 0; i < 17; i++) begin
			v = rnd();
			v = (i < 16) ? 8'(i) : (v | 8'h10);
			wr(OFS_SER_FMT, v);
			if (v <= 8'h08)
				cur = v;
			chk_reg("format", OFS_SER_FMT, cur);
			`CHK("rx pins", fmt_pins(cur[3:0]), {rj, wl})
		end
		$display("format test done");
		for (int k = 0; k < 3; k++) begin
			ratio = rt[k];
			repeat (3) @(posedge fclk);
			wt(200);
			chk_reg("clk status", OFS_CLK_STATUS, {3'h3, rc[k], 2'b00});
			rdr(OFS_ERR_FLAGS);
			`CHK("change flags", 8'hb0, rd & 8'hb0)
			wr(OFS_ERR_FLAGS, 8'h00);
			chk_reg("errors", OFS_ERR_FLAGS, 8'h00);
			`CHK("soft ramp", 1'b1, lvl < 10'd512)
		end
		$display("link test done");
		for (int i = 0; i < 3; i++) begin
			v = rnd();
			flt = 3'(1 << i);
			wt(1 + int'(v[1:0]));
			flt = 3'h0;
			wr(OFS_ERR_FLAGS, 8'hff);
			chk_reg("fault kept", OFS_ERR_FLAGS, fm[i]);
			wr(OFS_ERR_FLAGS, 8'h00);
			chk_reg("fault cleared", OFS_ERR_FLAGS, 8'h00);
			flt = 3'(1 << i);
			wr(OFS_ERR_FLAGS, 8'h00);
			chk_reg("fault held", OFS_ERR_FLAGS, fm[i]);
			flt = 3'h0;
			wr(OFS_ERR_FLAGS, 8'h00);
		end
		$display("fault test done");
		wr(OFS_SYS_CTRL1, 8'ha0);
		ratio = 10'd256; // shorter frames for the recovery
		run = 1'b0;
		wt(9000);
		`CHK("stall fault", 1'b1, cf)
		run = 1'b1;
		repeat (3) @(posedge fclk);
		wt(200);
		`CHK("hard unmute", 10'd512, lvl)
		rdr(OFS_ERR_FLAGS);
		`CHK("stall flag", 1'b1, rd[7])
		$display("unmute test done");
		summarize();
	end
endmodule
`default_nettype wire
